// File: src/dual_watchdog_timers.sv
// Dual watchdog: a system watchdog ticking on clk and an independent
// watchdog ticking on rising edges of its own oscillator input.
// Assumes ind_osc is already synchronous to clk and much slower than it;
// configuration inputs are static levels; refresh inputs are pulses.
//
// Overview of operation
// - System watchdog 14-bit down-counter, refresh reloads.
// - System underflow can reset the MCU.
// - System underflow may raise NMI or interrupt instead.
// - System refresh only allowed inside configured window.
// - Independent watchdog 14-bit down-counter, software services it.
// - Independent underflow resets, NMI or interrupt.
// - Independent counter runs from its dedicated oscillator.
// - Independent restarts after reset, underflow, refresh error.
// - Software refresh also restarts the independent counter.
`timescale 1ns/1ps
`include "dual_watchdog_params.svh"

module dual_watchdog_timers
  import dual_watchdog_pkg::*;
(
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  rst_b,
  // System watchdog control
  input  wire logic                  sys_refresh,
  input  wire wd_action_t            sys_action,
  input  wire wd_count_t             sys_win_hi,
  input  wire wd_count_t             sys_win_lo,
  // Independent watchdog control
  input  wire logic                  ind_osc,
  input  wire logic                  ind_refresh,
  input  wire wd_action_t            ind_action,
  // Status flag clear, one bit per flag
  input  wire logic [`WD_FLAG_W-1:0] flag_clear,
  // Requests to reset generator and interrupt controller
  output logic                       mcu_reset_req,
  output logic                       nmi_req,
  output logic                       irq_req,
  // Status
  output logic [`WD_FLAG_W-1:0]      flags,
  output wd_count_t                  sys_count,
  output wd_count_t                  ind_count
);

  typedef struct packed {
    logic                  osc_q;
    logic                  mcu_reset_req;
    logic                  nmi_req;
    logic                  irq_req;
    logic [`WD_FLAG_W-1:0] flags;
    wd_count_t             sys_count;
    wd_count_t             ind_count;
  } top_state_t;

  top_state_t st_ff;
  top_state_t nxt_st;

  logic                  ind_tick;
  wd_count_t             sys_cnt;
  wd_count_t             ind_cnt;
  logic                  sys_uf;
  logic                  sys_err;
  logic                  ind_uf;
  logic                  ind_err;
  logic                  sys_event;
  logic                  ind_event;
  logic [`WD_FLAG_W-1:0] flag_set;

  // One tick per rising edge of the dedicated oscillator
  assign ind_tick = ind_osc & ~st_ff.osc_q;

  watchdog_counter u_system_watchdog (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (1'b1),
    .refresh     (sys_refresh),
    .win_hi      (sys_win_hi),
    .win_lo      (sys_win_lo),
    .count       (sys_cnt),
    .underflow   (sys_uf),
    .refresh_err (sys_err)
  );

  // Independent watchdog accepts a refresh at any count
  watchdog_counter u_independent_watchdog (
    .clk         (clk),
    .rst_b       (rst_b),
    .tick        (ind_tick),
    .refresh     (ind_refresh),
    .win_hi      (`WD_WIN_FULL_HI),
    .win_lo      (`WD_WIN_FULL_LO),
    .count       (ind_cnt),
    .underflow   (ind_uf),
    .refresh_err (ind_err)
  );

  assign sys_event = sys_uf | sys_err;
  assign ind_event = ind_uf | ind_err;

  always_comb begin
    flag_set                   = '0;
    flag_set[`WD_FLAG_SYS_UF]  = sys_uf;
    flag_set[`WD_FLAG_SYS_ERR] = sys_err;
    flag_set[`WD_FLAG_IND_UF]  = ind_uf;
    flag_set[`WD_FLAG_IND_ERR] = ind_err;

    nxt_st           = st_ff;
    nxt_st.osc_q     = ind_osc;
    nxt_st.sys_count = sys_cnt;
    nxt_st.ind_count = ind_cnt;
    // Set wins over a clear in the same cycle
    nxt_st.flags     = (st_ff.flags & ~flag_clear) | flag_set;

    nxt_st.mcu_reset_req = (sys_event && (sys_action == ACT_RESET)) ||
                           (ind_event && (ind_action == ACT_RESET));
    nxt_st.nmi_req       = (sys_event && (sys_action == ACT_NMI)) ||
                           (ind_event && (ind_action == ACT_NMI));
    nxt_st.irq_req       = (sys_event && (sys_action == ACT_IRQ)) ||
                           (ind_event && (ind_action == ACT_IRQ));
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{osc_q: 1'b0, mcu_reset_req: 1'b0, nmi_req: 1'b0, irq_req: 1'b0,
                 flags: `WD_FLAG_RST, sys_count: `WD_RELOAD, ind_count: `WD_RELOAD};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign mcu_reset_req = st_ff.mcu_reset_req;
  assign nmi_req       = st_ff.nmi_req;
  assign irq_req       = st_ff.irq_req;
  assign flags         = st_ff.flags;
  assign sys_count     = st_ff.sys_count;
  assign ind_count     = st_ff.ind_count;

endmodule : dual_watchdog_timers

// File: src/dual_watchdog_params.svh
// Constants for the dual watchdog block: widths, reload and window values.
// Included by the package and the design modules; definitions only.
`ifndef DUAL_WATCHDOG_PARAMS_SVH
`define DUAL_WATCHDOG_PARAMS_SVH

`define WD_CNT_W         14
`define WD_RELOAD        14'h3FFF
`define WD_WIN_FULL_HI   14'h3FFF
`define WD_WIN_FULL_LO   14'h0000
`define WD_CNT_ZERO      14'h0000
`define WD_CNT_ONE       14'h0001
`define WD_FLAG_W        4
`define WD_FLAG_SYS_UF   0
`define WD_FLAG_SYS_ERR  1
`define WD_FLAG_IND_UF   2
`define WD_FLAG_IND_ERR  3
`define WD_FLAG_RST      4'h0

`endif

// File: src/dual_watchdog_pkg.sv
// Types shared by the dual watchdog modules.
// Assumes the params header is on the include path.
`include "dual_watchdog_params.svh"

package dual_watchdog_pkg;

  typedef logic [`WD_CNT_W-1:0] wd_count_t;

  // Action taken when a watchdog expires or is refreshed wrongly
  typedef enum logic [1:0] {
    ACT_RESET = 2'b00,
    ACT_NMI   = 2'b01,
    ACT_IRQ   = 2'b10,
    ACT_NONE  = 2'b11
  } wd_action_t;

endpackage : dual_watchdog_pkg

// File: src/watchdog_counter.sv
// One 14-bit watchdog down-counter with a refresh-permitted window.
// Assumes tick and refresh are synchronous to clk; refresh is a one-cycle pulse, tick may be held high.
`timescale 1ns/1ps
`include "dual_watchdog_params.svh"

module watchdog_counter
  import dual_watchdog_pkg::*;
(
  // Clock and reset
  input  wire logic      clk,
  input  wire logic      rst_b,
  // Count control
  input  wire logic      tick,
  input  wire logic      refresh,
  input  wire wd_count_t win_hi,
  input  wire wd_count_t win_lo,
  // Results
  output wd_count_t      count,
  output logic           underflow,
  output logic           refresh_err
);

  typedef struct packed {
    wd_count_t count;
    logic      underflow;
    logic      refresh_err;
  } cnt_state_t;

  cnt_state_t st_ff;
  cnt_state_t nxt_st;

  always_comb begin
    nxt_st             = st_ff;
    nxt_st.underflow   = 1'b0;
    nxt_st.refresh_err = 1'b0;
    if (refresh) begin
      // Refresh restarts the count whether or not it was in the window
      nxt_st.count = `WD_RELOAD;
      if ((st_ff.count > win_hi) || (st_ff.count < win_lo)) begin
        nxt_st.refresh_err = 1'b1;
      end
    end else if (tick) begin
      if (st_ff.count == `WD_CNT_ZERO) begin
        nxt_st.underflow = 1'b1;
        nxt_st.count     = `WD_RELOAD;
      end else begin
        nxt_st.count = st_ff.count - `WD_CNT_ONE;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_ff <= '{count: `WD_RELOAD, underflow: 1'b0, refresh_err: 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign count       = st_ff.count;
  assign underflow   = st_ff.underflow;
  assign refresh_err = st_ff.refresh_err;

endmodule : watchdog_counter

// File: tb/dual_watchdog_properties.sv
// Checker on the dual watchdog top ports.
// Assumes registered counts and flags as handed over.
`timescale 1ns/1ps
`include "dual_watchdog_params.svh"
module dual_watchdog_properties
  import dual_watchdog_pkg::*;
(
  input wire logic       clk,
  input wire logic       rst_b,
  input wire logic       sys_refresh,
  input wire wd_action_t sys_action,
  input wire wd_count_t  sys_win_hi,
  input wire wd_count_t  sys_win_lo,
  input wire logic       ind_osc,
  input wire logic       ind_refresh,
  input wire logic       mcu_reset_req,
  input wire logic       nmi_req,
  input wire logic       irq_req,
  input wire logic [3:0] flags,
  input wire wd_count_t  sys_count,
  input wire wd_count_t  ind_count
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_sys_reload: assert property (sys_refresh |-> ##2 sys_count == `WD_RELOAD)
    else $error("sys reload");
  a_sys_step: assert property (sys_count > 14'h0 && !$past(sys_refresh) && $past(rst_b)
    |=> sys_count == $past(sys_count) - 14'h1) else $error("sys step");
  a_sys_reset: assert property (sys_count == 14'h0 && !$past(sys_refresh)
    |=> flags[0] && (sys_action != ACT_RESET || mcu_reset_req)) else $error("sys rst");
  a_sys_intr: assert property (sys_count == 14'h0 && !$past(sys_refresh) |=>
    (sys_action != ACT_NMI || nmi_req) && (sys_action != ACT_IRQ || irq_req))
    else $error("sys intr");
  a_win_err: assert property ($past(sys_refresh) && (sys_count > sys_win_hi ||
    sys_count < sys_win_lo) |=> flags[1] && (sys_action != ACT_RESET || mcu_reset_req))
    else $error("win err");
  a_win_ok: assert property ($past(sys_refresh) && !$past(sys_refresh, 2) && !flags[1]
    && sys_count <= sys_win_hi && sys_count >= sys_win_lo |=> !flags[1]) else $error("win ok");
  a_ind_reload: assert property (ind_refresh |-> ##2 ind_count == `WD_RELOAD)
    else $error("ind reload");
  a_ind_hold: assert property ($stable(ind_osc) && !ind_refresh
    |=> ##1 ind_count == $past(ind_count)) else $error("ind hold");
  a_ind_flag: assert property (ind_count == 14'h0 && !ind_refresh |-> ##[1:6] flags[2])
    else $error("ind flag");
  a_ind_restart: assert property ($rose(flags[2]) |-> ind_count == `WD_RELOAD)
    else $error("ind restart");
endmodule : dual_watchdog_properties

bind dual_watchdog_timers dual_watchdog_properties u_dual_watchdog_properties (
  .clk           (clk),
  .rst_b         (rst_b),
  .sys_refresh   (sys_refresh),
  .sys_action    (sys_action),
  .sys_win_hi    (sys_win_hi),
  .sys_win_lo    (sys_win_lo),
  .ind_osc       (ind_osc),
  .ind_refresh   (ind_refresh),
  .mcu_reset_req (mcu_reset_req),
  .nmi_req       (nmi_req),
  .irq_req       (irq_req),
  .flags         (flags),
  .sys_count     (sys_count),
  .ind_count     (ind_count)
);

// File: tb/wd_partner.sv
// Reset generator and interrupt controller stand-in: counts requests.
// Assumes each request is a one-cycle pulse.
`timescale 1ns/1ps
module wd_partner (
  input wire logic clk,
  input wire logic mcu_reset_req,
  input wire logic nmi_req,
  input wire logic irq_req
);
  int n_rst = 0;
  int n_nmi = 0;
  int n_irq = 0;
  always @(posedge clk) begin
    n_rst <= n_rst + mcu_reset_req;
    n_nmi <= n_nmi + nmi_req;
    n_irq <= n_irq + irq_req;
  end
endmodule : wd_partner

// File: tb/testbench.sv
// Bench for the dual watchdog: underflow actions, window, refresh.
// Assumes design, package and params header compile first.
`timescale 1ns/1ps
`include "dual_watchdog_params.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin n_mismatch++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench
  import dual_watchdog_pkg::*;
;
  logic       clk = 0, rst_b = 0, sys_refresh = 0, ind_osc = 0, ind_refresh = 0;
  logic       mcu_reset_req, nmi_req, irq_req;
  wd_action_t sys_action = ACT_RESET, ind_action = ACT_RESET;
  wd_count_t  sys_win_hi = 14'h3F00, sys_win_lo = 14'h3E00, sys_count, ind_count;
  logic [3:0] flag_clear = 4'h0, flags;
  int         n_mismatch = 0, checked = 0, n, r, osc_cnt = 0;
  dual_watchdog_timers u_dual_watchdog_timers (
    .clk           (clk),
    .rst_b         (rst_b),
    .sys_refresh   (sys_refresh),
    .sys_action    (sys_action),
    .sys_win_hi    (sys_win_hi),
    .sys_win_lo    (sys_win_lo),
    .ind_osc       (ind_osc),
    .ind_refresh   (ind_refresh),
    .ind_action    (ind_action),
    .flag_clear    (flag_clear),
    .mcu_reset_req (mcu_reset_req),
    .nmi_req       (nmi_req),
    .irq_req       (irq_req),
    .flags         (flags),
    .sys_count     (sys_count),
    .ind_count     (ind_count)
  );
  wd_partner u_wd_partner (
    .clk           (clk),
    .mcu_reset_req (mcu_reset_req),
    .nmi_req       (nmi_req),
    .irq_req       (irq_req)
  );
  initial forever #12.5 clk = ~clk;
  // Dedicated oscillator: one rising edge every third cycle
  always @(posedge clk) begin
    osc_cnt <= (osc_cnt + 1) % 3;
    ind_osc <= rst_b && osc_cnt == 2;
  end
  task print_verdict();
    $display("mismatches=%0d checks=%0d", n_mismatch, checked);
    if (n_mismatch == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : print_verdict
  task t_ind_refresh();
    @(posedge clk) ind_refresh <= 1'b1;
    @(posedge clk) ind_refresh <= 1'b0;
    @(posedge clk) #1 `CHK(ind_count, `WD_RELOAD)
  endtask : t_ind_refresh
  task t_underflow();
    for (int a = 0; a < 4; a++) begin
      @(posedge clk) flag_clear <= 4'h1;
      sys_action <= wd_action_t'(a);
      @(posedge clk) flag_clear <= 4'h0;
      n = 2;
      // Look once the clear has landed, not in the edge's own time step
      #1;
      while (flags[0] !== 1'b1 && n < 20000) begin
        @(posedge clk) #1 n++;
      end
      `CHK(flags[0], 1'b1)
      if (a > 0) `CHK(n, 16384)
    end
    `CHK(u_wd_partner.n_rst, 2)
    `CHK(u_wd_partner.n_nmi, 1)
    `CHK(u_wd_partner.n_irq, 1)
    `CHK(flags[2], 1'b1)
    `CHK(flags[3], 1'b0)
  endtask : t_underflow
  // Early refresh must err; a refresh inside the window must not
  task t_window();
    @(posedge clk) sys_action <= ACT_RESET;
    sys_refresh <= 1'b1;
    @(posedge clk) sys_refresh <= 1'b0;
    repeat (4) @(posedge clk);
    flag_clear <= 4'h2;
    @(posedge clk) flag_clear <= 4'h0;
    r = u_wd_partner.n_rst;
    sys_refresh <= 1'b1;
    @(posedge clk) sys_refresh <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK(flags[1], 1'b1)
    `CHK(u_wd_partner.n_rst, r + 1)
    @(posedge clk) flag_clear <= 4'h2;
    @(posedge clk) flag_clear <= 4'h0;
    repeat (300) @(posedge clk);
    sys_refresh <= 1'b1;
    @(posedge clk) sys_refresh <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK(flags[1], 1'b0)
    // Late refresh, below the window, with the NMI action selected
    repeat (600) @(posedge clk);
    r = u_wd_partner.n_nmi;
    sys_action  <= ACT_NMI;
    sys_refresh <= 1'b1;
    @(posedge clk) sys_refresh <= 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK(flags[1], 1'b1)
    `CHK(u_wd_partner.n_nmi, r + 1)
  endtask : t_window
  initial begin
    repeat (8) @(posedge clk);
    rst_b <= 1'b1;
    t_ind_refresh();
    t_underflow();
    t_window();
    print_verdict();
  end
  initial begin
    #2000000;
    n_mismatch++;
    print_verdict();
  end
endmodule : testbench
